// file: rx_ctl_regs.svh
`ifndef RX_CTL_REGS_SVH
`define RX_CTL_REGS_SVH

// Register byte offsets
`define RXC_CTRL_OFS        8'h00
`define RXC_STATUS_OFS      8'h04
`define RXC_INT_STAT_OFS    8'h08
`define RXC_INT_MASK_OFS    8'h0C
`define RXC_ERR_TOTAL_OFS   8'h10
`define RXC_PRE_LO_OFS      8'h14
`define RXC_PRE_HI_OFS      8'h18

// Field positions
`define RXC_CTRL_GATE_BIT   0
`define RXC_INT_ALIGN_BIT   0
`define RXC_INT_FERR_BIT    1
`define RXC_INT_DROP_BIT    2
`define RXC_INT_W           3

// Reset values
`define RXC_CTRL_RST        1'b1
`define RXC_INT_MASK_RST    3'h0

// Timing
`define RXC_CLK_PERIOD_NS   10
`define RXC_MIN_PULSE_NS    5
`define RXC_MIN_PULSE_CYC   ((`RXC_MIN_PULSE_NS + `RXC_CLK_PERIOD_NS - 1) / `RXC_CLK_PERIOD_NS)
`define RXC_HOLD_CYC        16

`endif

// file: rx_ctl_pkg.sv
package rx_ctl_pkg;

  typedef enum logic [1:0] {ST_ALIGN, ST_RUN, ST_DRAIN, ST_OFF} rx_state_t;

  // One word arriving from the PCS decoder
  typedef struct packed {
    logic        valid;
    logic        start;
    logic        last;
    logic [55:0] preamble;
  } pcs_word_t;

  // Segmented local bus framing towards user logic
  typedef struct packed {
    logic valid;
    logic start;
    logic last;
  } bus_word_t;

endpackage

// file: rx_realign_sync.sv
`timescale 1ns/100ps
`default_nettype none

module rx_realign_sync
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Asynchronous request
  input  wire logic rx_realign_request,
  // Synchronised results
  output logic      realign_level,
  output logic      realign_event
);

  logic tog_r;
  logic tog_s1_r;
  logic tog_s2_r;
  logic tog_s3_r;
  logic lvl_s1_r;
  logic lvl_s2_r;

  // A pulse shorter than a clock period still flips this toggle
  always_ff @(posedge rx_realign_request or negedge presetn)
  begin
    if (!presetn)
      tog_r <= 1'b0;
    else
      tog_r <= ~tog_r;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tog_s1_r      <= 1'b0;
      tog_s2_r      <= 1'b0;
      tog_s3_r      <= 1'b0;
      realign_event <= 1'b0;
    end
    else
    begin
      tog_s1_r      <= tog_r;
      tog_s2_r      <= tog_s1_r;
      tog_s3_r      <= tog_s2_r;
      realign_event <= tog_s2_r ^ tog_s3_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lvl_s1_r      <= 1'b0;
      lvl_s2_r      <= 1'b0;
      realign_level <= 1'b0;
    end
    else
    begin
      lvl_s1_r      <= rx_realign_request;
      lvl_s2_r      <= lvl_s1_r;
      realign_level <= lvl_s2_r;
    end
  end

  chk_toggle_event: assert property (@(posedge pclk) disable iff (!presetn)
    (tog_s2_r != tog_s3_r) |=> realign_event)
    else $error("realign toggle seen without event");

endmodule // rx_realign_sync

`default_nettype wire

// file: rx_path_control_status.sv
`timescale 1ns/100ps
`default_nettype none
`include "rx_ctl_regs.svh"

module rx_path_control_status
  import rx_ctl_pkg::*;
#(
  parameter int LANES    = 20,
  parameter int PRE_W    = 56,
  parameter int HOLD_CYC = `RXC_HOLD_CYC
)
(
  // Clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic                      pready,
  output logic [31:0]               prdata,
  output logic                      pslverr,
  output logic                      irq,
  // User controls
  input  wire logic                 receive_path_on,
  input  wire logic                 rx_realign_request,
  // PCS side
  input  wire pcs_word_t            pcs_word,
  input  wire logic [LANES-1:0]     pcs_lane_err_valid,
  input  wire logic [LANES-1:0][1:0] pcs_lane_err_cnt,
  output logic                      pcs_decode_on,
  output logic                      rx_path_reset,
  // Segmented local bus and statistics
  output bus_word_t                 segmented_local_bus,
  output logic [PRE_W-1:0]          rx_preamble_capture,
  output logic [LANES-1:0]          framing_err_valid,
  output logic [LANES-1:0][1:0]     framing_err_cnt
);

  localparam int CNT_W = $clog2(HOLD_CYC + 1);

  rx_state_t            state_r;
  logic [CNT_W-1:0]     hold_cnt_r;
  logic                 ctrl_gate_r;
  logic [`RXC_INT_W-1:0] int_stat_r;
  logic [`RXC_INT_W-1:0] int_mask_r;
  logic [31:0]          err_total_r;
  logic                 realign_level;
  logic                 realign_event;
  logic                 realign_go;
  logic                 rx_on;
  logic                 accepting;
  logic                 take_start;
  logic                 take_end;
  logic                 drop_start;
  logic                 apb_setup;
  logic                 apb_wr;
  logic [`RXC_INT_W-1:0] int_set;

  function automatic logic [31:0] lane_err_sum(input logic [LANES-1:0] vld,
                                               input logic [LANES-1:0][1:0] cnt);
    logic [31:0] s;
    s = 32'h0;
    for (int i = 0; i < LANES; i++)
      if (vld[i])
        s = s + {30'h0, cnt[i]};
    return s;
  endfunction

  rx_realign_sync u_sync
  (
    .pclk               (pclk),
    .presetn            (presetn),
    .rx_realign_request (rx_realign_request),
    .realign_level      (realign_level),
    .realign_event      (realign_event)
  );

  assign realign_go = realign_level | realign_event;
  assign rx_on      = receive_path_on & ctrl_gate_r;
  assign accepting  = (state_r == ST_RUN) || (state_r == ST_DRAIN);
  assign take_start = accepting && pcs_word.valid && pcs_word.start;
  assign take_end   = accepting && pcs_word.valid && pcs_word.last;
  assign drop_start = (state_r == ST_OFF) && pcs_word.valid && pcs_word.start;
  assign apb_setup  = psel && !penable;
  assign apb_wr     = psel && penable && pready && pwrite;

  // Receive state machine
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_r <= ST_ALIGN;
    else if (realign_go)
      state_r <= ST_ALIGN;
    else
    begin
      unique case (state_r)
        ST_ALIGN:
          if (hold_cnt_r == '0)
            state_r <= rx_on ? ST_RUN : ST_OFF;
        ST_RUN:
          if (!rx_on)
            state_r <= (pcs_word.valid && pcs_word.last) ? ST_OFF : ST_DRAIN;
        ST_DRAIN:
          if (rx_on)
            state_r <= ST_RUN;
          else if (take_end)
            state_r <= ST_OFF;
        ST_OFF:
          if (rx_on)
            state_r <= ST_RUN;
      endcase
    end
  end

  // Realignment hold time
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hold_cnt_r <= CNT_W'(HOLD_CYC);
    else if (realign_go)
      hold_cnt_r <= CNT_W'(HOLD_CYC);
    else if (hold_cnt_r != '0)
      hold_cnt_r <= hold_cnt_r - 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_path_reset <= 1'b1;
      pcs_decode_on <= 1'b0;
    end
    else
    begin
      rx_path_reset <= realign_go || (hold_cnt_r != '0);
      pcs_decode_on <= !realign_go && (hold_cnt_r == '0) &&
                       (rx_on || (state_r == ST_RUN) || (state_r == ST_DRAIN));
    end
  end

  // Local bus forwarding, idle unless decoding
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      segmented_local_bus <= '0;
    else if (accepting && !realign_go)
    begin
      segmented_local_bus.valid <= pcs_word.valid;
      segmented_local_bus.start <= pcs_word.valid && pcs_word.start;
      segmented_local_bus.last  <= pcs_word.valid && pcs_word.last;
    end
    else
      segmented_local_bus <= '0;
  end

  // Preamble of the latest accepted frame
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rx_preamble_capture <= '0;
    else if (take_start && !realign_go)
      rx_preamble_capture <= pcs_word.preamble;
  end

  // Per-lane sync header error increments
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      framing_err_valid <= '0;
      framing_err_cnt   <= '0;
    end
    else
    begin
      framing_err_valid <= (accepting && !realign_go) ? pcs_lane_err_valid : '0;
      framing_err_cnt   <= pcs_lane_err_cnt;
    end
  end

  // Running total of valid increments
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      err_total_r <= 32'h0;
    else
      err_total_r <= err_total_r + lane_err_sum(framing_err_valid, framing_err_cnt);
  end

  // Control and mask registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_gate_r <= `RXC_CTRL_RST;
      int_mask_r  <= `RXC_INT_MASK_RST;
    end
    else if (apb_wr && paddr == `RXC_CTRL_OFS)
      ctrl_gate_r <= pwdata[`RXC_CTRL_GATE_BIT];
    else if (apb_wr && paddr == `RXC_INT_MASK_OFS)
      int_mask_r <= pwdata[`RXC_INT_W-1:0];
  end

  always_comb
  begin
    int_set = '0;
    int_set[`RXC_INT_ALIGN_BIT] = (state_r == ST_ALIGN) && (hold_cnt_r == '0) && !realign_go;
    int_set[`RXC_INT_FERR_BIT]  = |framing_err_valid;
    int_set[`RXC_INT_DROP_BIT]  = drop_start;
  end

  // Sticky status, write one to clear, a new event wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      int_stat_r <= '0;
    else if (apb_wr && paddr == `RXC_INT_STAT_OFS)
      int_stat_r <= (int_stat_r & ~pwdata[`RXC_INT_W-1:0]) | int_set;
    else
      int_stat_r <= int_stat_r | int_set;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(int_stat_r & int_mask_r);
  end

  // APB answer: no wait states, data prepared in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= apb_setup;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
      if (apb_setup)
      begin
        case (paddr)
          `RXC_CTRL_OFS:      prdata <= {31'h0, ctrl_gate_r};
          `RXC_STATUS_OFS:    prdata <= {27'h0, rx_on, pcs_decode_on,
                                         rx_path_reset, state_r};
          `RXC_INT_STAT_OFS:  prdata <= {29'h0, int_stat_r};
          `RXC_INT_MASK_OFS:  prdata <= {29'h0, int_mask_r};
          `RXC_ERR_TOTAL_OFS: prdata <= err_total_r;
          `RXC_PRE_LO_OFS:    prdata <= rx_preamble_capture[31:0];
          `RXC_PRE_HI_OFS:    prdata <= {8'h0, rx_preamble_capture[PRE_W-1:32]};
          default:            pslverr <= 1'b1;
        endcase
      end
    end
  end

  chk_drain_finish: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_DRAIN && take_end && !rx_on && !realign_go) |=> state_r == ST_OFF)
    else $error("drain did not stop after the packet end");

  chk_off_decode: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_OFF && !rx_on && !realign_go) |=> !pcs_decode_on)
    else $error("decoding left on while reception is off");

  chk_drain_flow: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_DRAIN && pcs_word.valid && !realign_go) |=> segmented_local_bus.valid)
    else $error("packet in progress cut during drain");

  chk_off_idle: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_OFF) |=> (segmented_local_bus == '0) && (framing_err_valid == '0))
    else $error("bus or statistics active while reception is off");

  chk_off_preamble: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_OFF) |=> rx_preamble_capture == $past(rx_preamble_capture))
    else $error("preamble changed while reception is off");

  chk_realign_enter: assert property (@(posedge pclk) disable iff (!presetn)
    realign_go |=> (state_r == ST_ALIGN) && rx_path_reset && !pcs_decode_on)
    else $error("realign request did not reset the path");

  chk_realign_leave: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_ALIGN && hold_cnt_r == '0 && !realign_go) |=> state_r != ST_ALIGN)
    else $error("realign hold did not end");

  chk_pulse_caught: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(realign_event) |-> ##[1:2] (state_r == ST_ALIGN && hold_cnt_r != '0))
    else $error("short realign pulse was lost");

  chk_preamble_take: assert property (@(posedge pclk) disable iff (!presetn)
    (take_start && !realign_go) |=> rx_preamble_capture == $past(pcs_word.preamble))
    else $error("preamble not captured at frame start");

  chk_lane_count: assert property (@(posedge pclk) disable iff (!presetn)
    (accepting && !realign_go) |=> (framing_err_valid == $past(pcs_lane_err_valid)) &&
                                   (framing_err_cnt == $past(pcs_lane_err_cnt)))
    else $error("lane error values not forwarded");

  chk_cnt_any_cycle: assert property (@(posedge pclk) disable iff (!presetn)
    (pcs_lane_err_cnt != '0) |=> framing_err_cnt == $past(pcs_lane_err_cnt))
    else $error("lane error values not updated");

  chk_valid_gates: assert property (@(posedge pclk) disable iff (!presetn)
    (framing_err_valid == '0) |=> err_total_r == $past(err_total_r))
    else $error("error total moved without a valid strobe");

  chk_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    ((int_stat_r & int_mask_r) != '0) |=> irq)
    else $error("unmasked status did not raise the interrupt");

  chk_irq_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    ((int_stat_r & int_mask_r) == '0) |=> !irq)
    else $error("interrupt high with no unmasked status");

  chk_stat_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    (int_set != '0) |=> (int_stat_r & $past(int_set)) == $past(int_set))
    else $error("status event lost against a clear");

  chk_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=> pready)
    else $error("no ready in the access cycle");

  chk_level_start: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(realign_level) |=> (state_r == ST_ALIGN) && (hold_cnt_r == CNT_W'(HOLD_CYC)))
    else $error("synchronised realign level did not restart the hold");

endmodule // rx_path_control_status

`default_nettype wire

// file: rx_user_model.sv
`timescale 1ns/100ps
`default_nettype none

module rx_user_model
(
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Commands from the bench
  input  wire logic             want_on,
  input  wire logic             kick,
  // Statistics from the device
  input  wire logic [19:0]      framing_err_valid,
  input  wire logic [19:0][1:0] framing_err_cnt,
  // Towards the device, and the external error counter
  output logic                  receive_path_on,
  output logic                  rx_realign_request,
  output logic [31:0]           err_sum
);
  logic [31:0] inc;

  // Only strobed lanes add to the external counter
  always_comb
  begin
    inc = '0;
    for (int i = 0; i < 20; i++)
      if (framing_err_valid[i])
        inc = inc + 32'(framing_err_cnt[i]);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      receive_path_on    <= 1'b0;
      rx_realign_request <= 1'b0;
      err_sum            <= '0;
    end
    else
    begin
      receive_path_on    <= want_on;
      rx_realign_request <= kick;
      err_sum            <= err_sum + inc;
    end
  end
endmodule // rx_user_model

`default_nettype wire

// file: tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "rx_ctl_regs.svh"

module tb_top import rx_ctl_pkg::*;;
  logic             pclk = 1'b0;
  logic             presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic             want_on, kick, receive_path_on, rx_realign_request;
  logic             pcs_decode_on, rx_path_reset;
  logic [7:0]       paddr;
  logic [31:0]      pwdata, prdata, rd, err_sum;
  pcs_word_t        pcs_word;
  bus_word_t        segmented_local_bus;
  logic [19:0]      pcs_lane_err_valid, framing_err_valid;
  logic [19:0][1:0] pcs_lane_err_cnt, framing_err_cnt;
  logic [55:0]      rx_preamble_capture;
  int               fails = 0, check_count = 0, cycles = 0, n;

  always #5 pclk = ~pclk;

  rx_path_control_status #(.HOLD_CYC(4)) i_rx_path_control_status (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .irq, .receive_path_on,
    .rx_realign_request, .pcs_word, .pcs_lane_err_valid, .pcs_lane_err_cnt, .pcs_decode_on,
    .rx_path_reset, .segmented_local_bus, .rx_preamble_capture, .framing_err_valid,
    .framing_err_cnt);

  rx_user_model i_rx_user_model (.pclk, .presetn, .want_on, .kick, .framing_err_valid,
    .framing_err_cnt, .receive_path_on, .rx_realign_request, .err_sum);

  task end_sim;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      fails++;
      end_sim();
    end
  end

  task chk_sig(input logic [63:0] got, input logic [63:0] exp, input string m);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task chk_reg(input logic [31:0] got, input logic [31:0] exp, input string m);
    chk_sig(64'(got), 64'(exp), m);
  endtask

  // One APB transfer; holds the request until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk_reg(rd, exp, "register read");
  endtask

  task send(input logic [2:0] f, input logic [55:0] p, input logic [2:0] exp);
    pcs_word <= {f, p};
    @(posedge pclk);
    pcs_word <= '0;
    @(negedge pclk);
    chk_sig(64'(segmented_local_bus), 64'(exp), "local bus flags");
    @(posedge pclk);
  endtask

  task lanes(input logic [19:0] v, input logic [39:0] c, input logic [19:0] exp);
    pcs_lane_err_valid <= v;
    pcs_lane_err_cnt   <= c;
    @(posedge pclk);
    pcs_lane_err_valid <= '0;
    @(negedge pclk);
    chk_sig(64'(framing_err_valid), 64'(exp), "lane strobes");
    chk_sig(64'(framing_err_cnt), 64'(c), "lane counts");
    @(posedge pclk);
  endtask

  task wait_aligned;
    n = 0;
    while (rx_path_reset !== 1'b0 && n < 60)
    begin
      @(posedge pclk);
      n++;
    end
  endtask

  initial
  begin
    presetn            = 1'b0;
    psel               = 1'b0;
    penable            = 1'b0;
    pwrite             = 1'b0;
    paddr              = 8'h00;
    pwdata             = 32'h0;
    pcs_word           = '0;
    pcs_lane_err_valid = '0;
    pcs_lane_err_cnt   = '0;
    want_on            = 1'b0;
    kick               = 1'b0;
    repeat (8) @(posedge pclk);
    chk_sig(64'(rx_path_reset), 64'h1, "reset held");
    presetn <= 1'b1;
    want_on <= 1'b1;
    wait_aligned();
    rd_chk(`RXC_CTRL_OFS, 32'h1);
    rd_chk(`RXC_INT_MASK_OFS, 32'h0);
    rd_chk(`RXC_STATUS_OFS, 32'h19);
    apb(1'b1, `RXC_INT_STAT_OFS, 32'h7);
    rd_chk(`RXC_INT_STAT_OFS, 32'h0);
    apb(1'b0, 8'h1C, 32'h0);
    chk_reg(rd, 32'h0, "unmapped data");
    chk_sig(64'(err), 64'h1, "unmapped error");
    $display("test registers done");
    send(3'b110, 56'hA1B2C3D4E5F607, 3'b110);
    send(3'b101, 56'h0, 3'b101);
    chk_sig(64'(rx_preamble_capture), 64'hA1B2C3D4E5F607, "preamble");
    rd_chk(`RXC_PRE_LO_OFS, 32'hD4E5F607);
    rd_chk(`RXC_PRE_HI_OFS, 32'h00A1B2C3);
    $display("test frame done");
    lanes(20'h80021, 40'h800000CC01, 20'h80021);
    rd_chk(`RXC_ERR_TOTAL_OFS, 32'h6);
    chk_reg(err_sum, 32'h6, "external counter");
    rd_chk(`RXC_INT_STAT_OFS, 32'h2);
    chk_sig(64'(irq), 64'h0, "irq masked");
    apb(1'b1, `RXC_INT_MASK_OFS, 32'h2);
    repeat (2) @(posedge pclk);
    chk_sig(64'(irq), 64'h1, "irq raised");
    apb(1'b1, `RXC_INT_STAT_OFS, 32'h2);
    repeat (2) @(posedge pclk);
    chk_sig(64'(irq), 64'h0, "irq cleared");
    rd_chk(`RXC_INT_STAT_OFS, 32'h0);
    $display("test lanes done");
    send(3'b110, 56'h11223344556677, 3'b110);
    want_on <= 1'b0;
    repeat (2) @(posedge pclk);
    send(3'b100, 56'h0, 3'b100);
    send(3'b101, 56'h0, 3'b101);
    repeat (2) @(posedge pclk);
    rd_chk(`RXC_STATUS_OFS, 32'h3);
    chk_sig(64'(pcs_decode_on), 64'h0, "decode stopped");
    send(3'b110, 56'hFFEEDDCCBBAA99, 3'b000);
    lanes(20'h80021, 40'h800000CC01, 20'h0);
    chk_sig(64'(rx_preamble_capture), 64'h11223344556677, "preamble kept");
    rd_chk(`RXC_ERR_TOTAL_OFS, 32'h6);
    apb(1'b0, `RXC_INT_STAT_OFS, 32'h0);
    chk_reg(rd & 32'h4, 32'h4, "drop flag");
    want_on <= 1'b1;
    repeat (3) @(posedge pclk);
    rd_chk(`RXC_STATUS_OFS, 32'h19);
    apb(1'b1, `RXC_INT_STAT_OFS, 32'h7);
    apb(1'b1, `RXC_CTRL_OFS, 32'h0);
    rd_chk(`RXC_CTRL_OFS, 32'h0);
    rd_chk(`RXC_STATUS_OFS, 32'hA);
    apb(1'b1, `RXC_CTRL_OFS, 32'h1);
    $display("test disable done");
    kick <= 1'b1;
    @(posedge pclk);
    kick <= 1'b0;
    n = 0;
    while (rx_path_reset !== 1'b1 && n < 10)
    begin
      @(posedge pclk);
      n++;
    end
    chk_sig(64'(rx_path_reset), 64'h1, "realign reset");
    chk_sig(64'(pcs_decode_on), 64'h0, "decode held");
    send(3'b110, 56'h0123456789ABCD, 3'b000);
    wait_aligned();
    rd_chk(`RXC_STATUS_OFS, 32'h19);
    apb(1'b0, `RXC_INT_STAT_OFS, 32'h0);
    chk_reg(rd & 32'h1, 32'h1, "realign done");
    $display("test realign done");
    end_sim();
  end
endmodule // tb_top

`default_nettype wire
